// ### rmp_regs.svh
// register map, field positions, reset values and constants of the reading math unit
// assumes 32-bit classic wishbone with byte addresses, readings as signed 32-bit counts
`ifndef RMP_REGS_SVH
`define RMP_REGS_SVH

// register byte offsets
`define RMP_ADR_CTRL      8'h00
`define RMP_ADR_STATUS    8'h04
`define RMP_ADR_OFFSET    8'h08
`define RMP_ADR_DBREL     8'h0c
`define RMP_ADR_REFRES    8'h10
`define RMP_ADR_UPPER     8'h14
`define RMP_ADR_LOWER     8'h18
`define RMP_ADR_MIN       8'h1c
`define RMP_ADR_MAX       8'h20
`define RMP_ADR_AVG       8'h24
`define RMP_ADR_COUNT     8'h28

// control fields
`define RMP_CTRL_EN_BIT   0
`define RMP_CTRL_OP_LSB   1
`define RMP_CTRL_OP_MSB   3

// reset values
`define RMP_CTRL_RESET    32'h0000_0000
`define RMP_REF_DEFAULT   5'hb
`define RMP_REF_LAST      5'h10

// magnitude limits: 120% of the highest range, and 200.00 dBm in centi-dB
`define RMP_RANGE_LIMIT   32'h4786_8c00
`define RMP_DB_LIMIT      32'h0000_4e20

// dBm arithmetic: 20*log10(2) in centi-dB per log2 unit, and 30 dB - 120 dB for uV to mW
`define RMP_DB_PER_OCT    32'h0000_025a
`define RMP_DBM_SHIFT     32'h0000_2328

// divider iteration count minus one
`define RMP_DIV_LAST      6'h3f

`endif

// ### rmp_pkg.sv
// types shared by the reading math unit
// assumes rmp_regs.svh supplies the numeric constants
package rmp_pkg;

  // math operations, code order matches the control field
  typedef enum logic [2:0] {OP_NULL, OP_DB, OP_DBM, OP_AVG, OP_LIMIT} rmp_op_e;

  // measurement functions as delivered by the reading source
  typedef enum logic [3:0] {F_DCV, F_ACV, F_DCI, F_ACI, F_OHM2, F_OHM4,
                            F_FREQ, F_PER, F_CONT, F_DIODE, F_RATIO} rmp_func_e;

  // divider sequencing
  typedef enum logic {DIV_IDLE, DIV_RUN} rmp_div_e;

  // one processed reading with its flags
  typedef struct packed {
    logic [31:0] data;
    logic        pass;
    logic        high;
    logic        low;
  } rmp_result_s;

endpackage

// ### rmp_log2.sv
// combinational base-two logarithm of an unsigned magnitude, 5.8 fixed point
// assumes a nonzero input; zero is treated as one by the caller
`timescale 1ns/1ps
`include "rmp_regs.svh"

module rmp_log2 (
  input  wire logic [31:0] mag,     // unsigned magnitude
  output logic      [12:0] log_q8   // integer part in [12:8], fraction in [7:0]
);
  logic [4:0]  msb;
  logic [31:0] norm;

  // leading one search, fraction taken linearly from the bits below it
  always_comb begin
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    norm   = mag << (5'h1f - msb);
    log_q8 = {msb, norm[30:23]};
  end
endmodule

// ### rmp_div.sv
// sequential unsigned divider for the running average, one bit per clock
// assumes start is a one-cycle pulse; a new start abandons a division in progress
`timescale 1ns/1ps
`include "rmp_regs.svh"

module rmp_div
  import rmp_pkg::*;
(
  input  wire logic        clk,       // system clock
  input  wire logic        rst,       // synchronous reset, active high
  input  wire logic        start,     // begin a division
  input  wire logic [63:0] dividend,  // unsigned sum
  input  wire logic [31:0] divisor,   // nonzero count
  output logic             done,      // quotient valid, one cycle
  output logic      [31:0] quotient   // low word of the quotient
);
  rmp_div_e    state;
  logic [5:0]  step;
  logic [32:0] rem;
  logic [63:0] quo;
  logic [32:0] trial;

  assign trial    = {rem[31:0], quo[63]};
  assign quotient = quo[31:0];

  // restoring division, 64 steps
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DIV_IDLE;
      step  <= 6'h00;
      rem   <= 33'h0;
      quo   <= 64'h0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        DIV_IDLE: begin
          if (start) begin
            rem   <= 33'h0;
            quo   <= dividend;
            step  <= 6'h00;
            state <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          if (trial >= {1'b0, divisor}) begin
            rem <= trial - {1'b0, divisor};
            quo <= {quo[62:0], 1'b1};
          end else begin
            rem <= trial;
            quo <= {quo[62:0], 1'b0};
          end
          step <= step + 6'h01;
          if (start) begin
            rem  <= 33'h0;
            quo  <= dividend;
            step <= 6'h00;
          end else if (step == `RMP_DIV_LAST) begin
            done  <= 1'b1;
            state <= DIV_IDLE;
          end
        end
        default: state <= DIV_IDLE;
      endcase
    end
  end
endmodule

// ### rmp_top.sv
// reading math post-processor: null, dB, dBm, min-max statistics, limit test
// assumes readings and function code come from logic on CORE_CLK, host on wishbone
//
// Behaviour
// - five operations, only one active; a new selection replaces the old one.
// - active operation ends on disable, function change, or reset.
// - null/min-max/limit/dB/dBm each allowed only with listed measurement functions.
// - selecting an operation not allowed with present function turns math off.
// - active valid operation replaced by invalid one raises settings-conflict error.
// - host picks operation, then enables; selection defaults to null.
// - first min-max reading loads min and max; later extremes replace them.
// - min-max counts readings and keeps average; all four readable.
// - pulse a new-extreme indication whenever min or max is updated after the first reading.
// - min-max values cleared on min-max turn-on and on reset.
// - null result is reading minus stored null value.
// - null value clamped to 120% of top range; cleared on reset/function change.
// - unwritten null value captured from first reading, giving zero result.
// - dB result is reading in dBm minus stored relative dBm value.
// - unwritten dB relative captured from first reading; resistance change leaves it.
// - dBm result is 10*log10(reading squared / resistance / 1 mW).
// - reference resistance one of 17 values, default 600, kept through reset.
// - limits clamped to 120% of top range, zero on reset/function change.
// - limit mode classifies each reading as pass, high or low.
// - service request on first failure; one beep on failure after a pass.
`timescale 1ns/1ps
`include "rmp_regs.svh"

module rmp_top
  import rmp_pkg::*;
(
  input  wire logic        CORE_CLK,      // system clock, 125 MHz
  input  wire logic        RST,           // synchronous reset, active high
  input  wire logic        WB_CYC_I,      // wishbone cycle
  input  wire logic        WB_STB_I,      // wishbone strobe
  input  wire logic        WB_WE_I,       // wishbone write enable
  input  wire logic [7:0]  WB_ADR_I,      // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,      // wishbone byte lanes
  input  wire logic [31:0] WB_DAT_I,      // wishbone write data
  output logic      [31:0] WB_DAT_O,      // wishbone read data
  output logic             WB_ACK_O,      // wishbone acknowledge
  input  wire logic [3:0]  FUNC_SEL,      // present measurement function
  input  wire logic        READING_VALID, // reading strobe
  input  wire logic [31:0] READING_DATA,  // signed reading
  output logic             RESULT_VALID,  // processed reading strobe
  output rmp_result_s      RESULT,        // processed reading and limit flags
  output logic             NEW_EXTREME,   // new minimum or maximum, pulse
  output logic             LIMIT_BEEP,    // failure after a pass, pulse
  output logic             LIMIT_SRQ,     // first failure since enable, pulse
  output logic             SET_CONFLICT   // settings conflict error, pulse
);

  // allowed operation / function pairs
  function automatic logic op_ok(rmp_op_e op, rmp_func_e f);
    logic volts;
    logic exotic;
    volts  = (f == F_DCV) || (f == F_ACV);
    exotic = (f == F_CONT) || (f == F_DIODE) || (f > F_RATIO);
    case (op)
      OP_NULL:         op_ok = !exotic && (f != F_RATIO);
      OP_AVG, OP_LIMIT: op_ok = !exotic;
      OP_DB, OP_DBM:   op_ok = volts;
      default:         op_ok = 1'b0;
    endcase
  endfunction

  // clamp a signed value to +-lim
  function automatic logic [31:0] clamp(logic [31:0] v, logic [31:0] lim);
    if (!v[31] && (v > lim)) begin
      clamp = lim;
    end else if (v[31] && ((32'h0 - v) > lim)) begin
      clamp = 32'h0 - lim;
    end else begin
      clamp = v;
    end
  endfunction

  // byte lane merge for writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd,
                                        logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // 10*log10 of the reference resistance in centi-dB
  function automatic logic [31:0] ref_cdb(logic [4:0] idx);
    case (idx)
      5'h00: ref_cdb = 32'h6a3;
      5'h01: ref_cdb = 32'h753;
      5'h02: ref_cdb = 32'h7b0;
      5'h03: ref_cdb = 32'h7f9;
      5'h04: ref_cdb = 32'h82d;
      5'h05: ref_cdb = 32'h831;
      5'h06: ref_cdb = 32'h852;
      5'h07: ref_cdb = 32'h880;
      5'h08: ref_cdb = 32'h95e;
      5'h09: ref_cdb = 32'h9ad;
      5'h0a: ref_cdb = 32'ha8b;
      5'h0b: ref_cdb = 32'hada;
      5'h0c: ref_cdb = 32'hb57;
      5'h0d: ref_cdb = 32'hb8a;
      5'h0e: ref_cdb = 32'hbb8;
      5'h0f: ref_cdb = 32'hc07;
      default: ref_cdb = 32'hf3f;
    endcase
  endfunction

  logic        math_enable;
  rmp_op_e     math_op_select;
  rmp_func_e   func_q;
  logic        func_chg;
  logic        wr;
  logic        rd_hit;
  logic [31:0] ctrl_wd;
  rmp_op_e     new_op;
  logic        activate;
  logic        deactivate;
  logic [4:0]  reference_resistance_select = `RMP_REF_DEFAULT; // kept through reset
  logic [31:0] offset_value;
  logic        offset_written;
  logic        offset_first;
  logic [31:0] db_relative;
  logic        db_written;
  logic        db_first;
  logic [31:0] upper_bound;
  logic [31:0] lower_bound;
  logic        s1_valid;
  logic [31:0] s1_data;
  logic [31:0] s1_mag;
  logic [12:0] log_q8;
  logic [31:0] dbm_now;
  logic [31:0] min_val;
  logic [31:0] max_val;
  logic [63:0] sum_val;
  logic [31:0] reading_count_query;
  logic [31:0] avg_val;
  logic        mm_first;
  logic        div_start;
  logic        div_done;
  logic [31:0] div_q;
  logic        fail_seen;
  logic        prev_pass;
  logic        use_op;
  logic        is_high;
  logic        is_low;

  assign func_chg = (rmp_func_e'(FUNC_SEL) != func_q);
  assign wr       = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I;
  assign rd_hit   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign ctrl_wd  = merge({28'h0, math_op_select, math_enable}, WB_DAT_I, WB_SEL_I);
  assign new_op   = rmp_op_e'(ctrl_wd[`RMP_CTRL_OP_MSB:`RMP_CTRL_OP_LSB]);
  // enabling a permitted operation, or replacing the active one
  assign activate = wr && (WB_ADR_I == `RMP_ADR_CTRL) && !func_chg &&
                    ctrl_wd[`RMP_CTRL_EN_BIT] && op_ok(new_op, func_q) &&
                    (!math_enable || (new_op != math_op_select));
  assign deactivate = func_chg;
  assign use_op   = math_enable && !func_chg;
  assign is_high  = $signed(s1_data) > $signed(upper_bound);
  assign is_low   = $signed(s1_data) < $signed(lower_bound);

  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= rd_hit;
      case (WB_ADR_I)
        `RMP_ADR_CTRL:   WB_DAT_O <= {28'h0, math_op_select, math_enable};
        `RMP_ADR_STATUS: WB_DAT_O <= {24'h0, mm_first, db_written, offset_written,
                                      func_q, math_enable};
        `RMP_ADR_OFFSET: WB_DAT_O <= offset_value;
        `RMP_ADR_DBREL:  WB_DAT_O <= db_relative;
        `RMP_ADR_REFRES: WB_DAT_O <= {27'h0, reference_resistance_select};
        `RMP_ADR_UPPER:  WB_DAT_O <= upper_bound;
        `RMP_ADR_LOWER:  WB_DAT_O <= lower_bound;
        `RMP_ADR_MIN:    WB_DAT_O <= min_val;
        `RMP_ADR_MAX:    WB_DAT_O <= max_val;
        `RMP_ADR_AVG:    WB_DAT_O <= avg_val;
        `RMP_ADR_COUNT:  WB_DAT_O <= reading_count_query;
        default:         WB_DAT_O <= 32'h0;
      endcase
    end
  end

  // function tracking; a change is flagged in the cycle FUNC_SEL moves, func_q follows one cycle later
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      func_q <= F_DCV;
    end else begin
      func_q <= rmp_func_e'(FUNC_SEL);
    end
  end

  // operation select and enable
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      math_enable    <= 1'b0;
      math_op_select <= OP_NULL;
      SET_CONFLICT   <= 1'b0;
    end else begin
      SET_CONFLICT <= 1'b0;
      if (deactivate) begin
        math_enable <= 1'b0;
      end else if (wr && (WB_ADR_I == `RMP_ADR_CTRL)) begin
        math_op_select <= new_op;
        // not permitted here: math goes off
        math_enable <= ctrl_wd[`RMP_CTRL_EN_BIT] && op_ok(new_op, func_q);
        if (math_enable && op_ok(math_op_select, func_q) &&
            !op_ok(new_op, func_q)) begin
          SET_CONFLICT <= 1'b1;
        end
      end
    end
  end

  // reference resistance has no reset: it survives reset like nonvolatile state
  always_ff @(posedge CORE_CLK) begin
    if (wr && (WB_ADR_I == `RMP_ADR_REFRES) && (WB_DAT_I[4:0] <= `RMP_REF_LAST)) begin
      reference_resistance_select <= WB_DAT_I[4:0];
    end
  end

  // null value: clear beats host write beats first-reading capture
  always_ff @(posedge CORE_CLK) begin
    if (RST || func_chg) begin
      offset_value   <= 32'h0;
      offset_written <= 1'b0;
      offset_first   <= 1'b0;
    end else if (wr && (WB_ADR_I == `RMP_ADR_OFFSET) && math_enable) begin
      offset_value   <= clamp(merge(offset_value, WB_DAT_I, WB_SEL_I),
                              `RMP_RANGE_LIMIT);
      offset_written <= 1'b1;
      offset_first   <= 1'b0;
    end else if (activate && (new_op == OP_NULL)) begin
      offset_first <= !offset_written;
    end else if (s1_valid && use_op && (math_op_select == OP_NULL) && offset_first) begin
      offset_value <= s1_data;
      offset_first <= 1'b0;
    end
  end

  // dB relative value, same priorities as the null value
  always_ff @(posedge CORE_CLK) begin
    if (RST || func_chg) begin
      db_relative <= 32'h0;
      db_written  <= 1'b0;
      db_first    <= 1'b0;
    end else if (wr && (WB_ADR_I == `RMP_ADR_DBREL) && math_enable) begin
      db_relative <= clamp(merge(db_relative, WB_DAT_I, WB_SEL_I),
                           `RMP_DB_LIMIT);
      db_written  <= 1'b1;
      db_first    <= 1'b0;
    end else if (activate && (new_op == OP_DB)) begin
      db_first <= !db_written;
    end else if (s1_valid && use_op && (math_op_select == OP_DB) && db_first) begin
      db_relative <= dbm_now;
      db_first    <= 1'b0;
    end
  end

  // limits
  always_ff @(posedge CORE_CLK) begin
    if (RST || func_chg) begin
      upper_bound <= 32'h0;
      lower_bound <= 32'h0;
    end else if (wr && (WB_ADR_I == `RMP_ADR_UPPER)) begin
      upper_bound <= clamp(merge(upper_bound, WB_DAT_I, WB_SEL_I), `RMP_RANGE_LIMIT);
    end else if (wr && (WB_ADR_I == `RMP_ADR_LOWER)) begin
      lower_bound <= clamp(merge(lower_bound, WB_DAT_I, WB_SEL_I), `RMP_RANGE_LIMIT);
    end
  end

  // input stage: one reading per strobe, no back-pressure
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_valid <= 1'b0;
      s1_data  <= 32'h0;
    end else begin
      s1_valid <= READING_VALID;
      if (READING_VALID) begin
        s1_data <= READING_DATA;
      end
    end
  end

  // dBm from the magnitude; zero is read as one count to keep the log finite
  assign s1_mag = s1_data[31] ? (32'h0 - s1_data) :
                  ((s1_data == 32'h0) ? 32'h1 : s1_data);

  rmp_log2 u_log2 (
    .mag    (s1_mag),
    .log_q8 (log_q8)
  );

  // 20*log10(V) + 30 - 10*log10(R), all in centi-dB
  always_comb begin
    dbm_now = (({19'h0, log_q8} * `RMP_DB_PER_OCT) >> 8) - `RMP_DBM_SHIFT
              - ref_cdb(reference_resistance_select);
  end

  // min-max statistics; turn-on clear wins over a reading in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      min_val             <= 32'h0;
      max_val             <= 32'h0;
      sum_val             <= 64'h0;
      reading_count_query <= 32'h0;
      mm_first            <= 1'b0;
      NEW_EXTREME         <= 1'b0;
      div_start           <= 1'b0;
    end else begin
      NEW_EXTREME <= 1'b0;
      div_start   <= 1'b0;
      if (activate && (new_op == OP_AVG)) begin
        min_val             <= 32'h0;
        max_val             <= 32'h0;
        sum_val             <= 64'h0;
        reading_count_query <= 32'h0;
        mm_first            <= 1'b1;
      end else if (s1_valid && use_op && (math_op_select == OP_AVG)) begin
        sum_val             <= sum_val + {{32{s1_data[31]}}, s1_data};
        reading_count_query <= reading_count_query + 32'h1;
        div_start           <= 1'b1;
        mm_first            <= 1'b0;
        if (mm_first) begin
          min_val <= s1_data;
          max_val <= s1_data;
        end else begin
          if ($signed(s1_data) < $signed(min_val)) begin
            min_val <= s1_data;
          end
          if ($signed(s1_data) > $signed(max_val)) begin
            max_val <= s1_data;
          end
          NEW_EXTREME <= ($signed(s1_data) < $signed(min_val)) ||
                         ($signed(s1_data) > $signed(max_val));
        end
      end
    end
  end

  // average lags the count by the divider's run; readers see the last finished one
  rmp_div u_div (
    .clk      (CORE_CLK),
    .rst      (RST),
    .start    (div_start),
    .dividend (sum_val[63] ? (64'h0 - sum_val) : sum_val),
    .divisor  (reading_count_query),
    .done     (div_done),
    .quotient (div_q)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST || (activate && (new_op == OP_AVG))) begin
      avg_val <= 32'h0;
    end else if (div_done) begin
      avg_val <= sum_val[63] ? (32'h0 - div_q) : div_q;
    end
  end

  // limit alerts: history restarts whenever limit mode is turned on
  always_ff @(posedge CORE_CLK) begin
    if (RST || (activate && (new_op == OP_LIMIT))) begin
      fail_seen  <= 1'b0;
      prev_pass  <= 1'b0;
      LIMIT_BEEP <= 1'b0;
      LIMIT_SRQ  <= 1'b0;
    end else begin
      LIMIT_BEEP <= 1'b0;
      LIMIT_SRQ  <= 1'b0;
      if (s1_valid && use_op && (math_op_select == OP_LIMIT)) begin
        prev_pass <= !(is_high || is_low);
        if (is_high || is_low) begin
          fail_seen  <= 1'b1;
          LIMIT_SRQ  <= !fail_seen;
          LIMIT_BEEP <= prev_pass;
        end
      end
    end
  end

  // result stage: exactly one result for each accepted reading
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RESULT_VALID <= 1'b0;
      RESULT       <= '0;
    end else begin
      RESULT_VALID <= s1_valid;
      if (s1_valid) begin
        RESULT <= '{data: s1_data, pass: 1'b0, high: 1'b0, low: 1'b0};
        if (use_op) begin
          case (math_op_select)
            OP_NULL:  RESULT.data <= offset_first ? 32'h0 :
                                     (s1_data - offset_value);
            OP_DB:    RESULT.data <= db_first ? 32'h0 :
                                     (dbm_now - db_relative);
            OP_DBM:   RESULT.data <= dbm_now;
            OP_LIMIT: begin
              RESULT.high <= is_high;
              RESULT.low  <= is_low && !is_high;
              RESULT.pass <= !(is_high || is_low);
            end
            default:  RESULT.data <= s1_data;
          endcase
        end
      end
    end
  end

endmodule

// ### rmp_top_assertions.sv
// port checks for the reading math unit
// assumes bind into rmp_top, one clock, synchronous reset
`timescale 1ns/1ps
module rmp_top_assertions
  import rmp_pkg::*;
(
  input wire logic        CORE_CLK,      // clock
  input wire logic        RST,           // reset
  input wire logic        WB_CYC_I,      // cycle
  input wire logic        WB_STB_I,      // strobe
  input wire logic        WB_ACK_O,      // ack
  input wire logic        READING_VALID, // reading in
  input wire logic        RESULT_VALID,  // result out
  input wire rmp_result_s RESULT,        // result
  input wire logic        NEW_EXTREME,   // extreme
  input wire logic        LIMIT_BEEP,    // beep
  input wire logic        LIMIT_SRQ,     // srq
  input wire logic        SET_CONFLICT   // conflict
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // an unanswered request, and a reading with its result
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_read;
    READING_VALID ##2 RESULT_VALID;
  endsequence
  a_ack_next: assert property (s_req |=> WB_ACK_O)
    else $error("ack late");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack long");
  a_result_delay: assert property (READING_VALID |-> s_read)
    else $error("result late");
  a_result_cause: assert property (RESULT_VALID |-> $past(READING_VALID, 2))
    else $error("result stray");
  a_extreme_sync: assert property (NEW_EXTREME |-> RESULT_VALID)
    else $error("extreme stray");
  a_beep_fail: assert property (LIMIT_BEEP |-> RESULT_VALID && !RESULT.pass)
    else $error("beep stray");
  a_srq_fail: assert property (LIMIT_SRQ |-> RESULT_VALID && !RESULT.pass)
    else $error("srq stray");
  a_conflict_ack: assert property (SET_CONFLICT |-> WB_ACK_O)
    else $error("conflict stray");
endmodule

// ### rmp_src.sv
// reading source model
// assumes the bench calls send from its clocked process
`timescale 1ns/1ps
module rmp_src (
  input  wire logic        clk,   // core clock
  output logic             valid, // strobe
  output logic      [31:0] data   // reading
);
  initial valid = 1'b0;
  initial data = 32'h0;
  // word inverted after the strobe so stale data never matches
  task automatic send(input logic [31:0] v);
    @(posedge clk);
    valid <= 1'b1;
    data  <= v;
    @(posedge clk);
    valid <= 1'b0;
    data  <= ~v;
  endtask
endmodule

// ### tb_rmp_top.sv
// bench for the reading math unit
// assumes rmp_pkg, rmp_src and the checker compiled first
`timescale 1ns/1ps
`include "rmp_regs.svh"
module tb_rmp_top
  import rmp_pkg::*;
;
  logic        clk, rst, cyc, stb, we, ack, rv, vld, ext, bp, beep, srq, conf, cf, nx, sq;
  logic [7:0]  adr;
  logic [3:0]  func;
  logic [31:0] dat, dat_o, rdg, q;
  rmp_result_s res, r;
  int          miscompares = 0;
  int          checks_done = 0;
  rmp_src i_rmp_src (.clk(clk), .valid(vld), .data(rdg));
  rmp_top i_rmp_top (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .FUNC_SEL(func), .READING_VALID(vld), .READING_DATA(rdg), .RESULT_VALID(rv),
    .RESULT(res), .NEW_EXTREME(ext), .LIMIT_BEEP(beep), .LIMIT_SRQ(srq), .SET_CONFLICT(conf));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a hang ends the run rather than stalling it
  task automatic stuck(input logic ok);
    if (!ok) miscompares++;
    if (!ok) wrap_up();
  endtask
  // classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 9);
    stuck(ack === 1'b1);
    q = dat_o;
    cf = conf;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [31:0] v);
    int n;
    i_rmp_src.send(v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rv !== 1'b1 && n < 6);
    stuck(rv === 1'b1);
    r = res;
    bp = beep;
    nx = ext;
    sq = srq;
  endtask
  task automatic t_base;
    wb(1'b0, `RMP_ADR_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    wb(1'b0, `RMP_ADR_REFRES, 32'h0);
    chk("refres", 32'(`RMP_REF_DEFAULT), q);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, q);
    rd(32'h5);
    chk("bypass", 32'h5, r.data);
    wb(1'b1, `RMP_ADR_CTRL, 32'h1);
    rd(32'h64);
    chk("capture", 32'h0, r.data);
    rd(32'h82);
    chk("null", 32'h1e, r.data);
    wb(1'b1, `RMP_ADR_OFFSET, 32'ha);
    rd(32'h32);
    chk("offset", 32'h28, r.data);
    $display("null test done");
  endtask
  task automatic t_stats;
    wb(1'b1, `RMP_ADR_CTRL, 32'h7);
    rd(32'ha);
    chk("first extreme", 32'h0, 32'(nx));
    rd(32'hffff_fffc);
    chk("new extreme", 32'h1, 32'(nx));
    rd(32'h14);
    wb(1'b0, `RMP_ADR_MIN, 32'h0);
    chk("min", 32'hffff_fffc, q);
    wb(1'b0, `RMP_ADR_MAX, 32'h0);
    chk("max", 32'h14, q);
    repeat (80) @(posedge clk);
    wb(1'b0, `RMP_ADR_AVG, 32'h0);
    chk("avg", 32'h8, q);
    wb(1'b0, `RMP_ADR_COUNT, 32'h0);
    chk("count", 32'h3, q);
    $display("stats test done");
  endtask
  task automatic t_limit;
    wb(1'b1, `RMP_ADR_UPPER, 32'h64);
    wb(1'b1, `RMP_ADR_LOWER, 32'hffff_ff9c);
    wb(1'b1, `RMP_ADR_CTRL, 32'h9);
    rd(32'h0);
    chk("pass", 32'h4, 32'({r.pass, r.high, r.low}));
    rd(32'hc8);
    chk("high", 32'h5, 32'({r.high, r.low, bp}));
    chk("srq first", 32'h1, 32'(sq));
    rd(32'hffff_ff38);
    chk("low", 32'h2, 32'({r.high, r.low, bp}));
    chk("srq once", 32'h0, 32'(sq));
    @(posedge clk);
    func <= 4'h2;
    repeat (3) @(posedge clk);
    wb(1'b0, `RMP_ADR_UPPER, 32'h0);
    chk("cleared", 32'h0, q);
    wb(1'b1, `RMP_ADR_CTRL, 32'h9);
    wb(1'b1, `RMP_ADR_CTRL, 32'h3);
    chk("conflict", 32'h1, 32'(cf));
    wb(1'b0, `RMP_ADR_STATUS, 32'h0);
    chk("off", 32'h0, 32'(q[0]));
    $display("limit test done");
  endtask
  // dB capture, one octave up, then dBm of 2^20 uV into 600 ohm (about 2.63 dBm)
  task automatic t_db;
    logic [31:0] d;
    @(posedge clk);
    func <= 4'h0;
    repeat (3) @(posedge clk);
    wb(1'b1, `RMP_ADR_CTRL, 32'h3);
    rd(32'h0010_0000);
    chk("db capture", 32'h0, r.data);
    rd(32'h0020_0000);
    chk("db octave", 32'h25a, r.data);
    wb(1'b1, `RMP_ADR_CTRL, 32'h5);
    rd(32'h0010_0000);
    // 8-bit log fraction: accept 260..266 centi-dB
    d = r.data - 32'h104;
    chk("dbm window", 32'h1, 32'(d < 32'h7));
    $display("db test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, cyc, stb, we, adr, dat, func} = {1'b1, 47'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_base();
    t_stats();
    t_limit();
    t_db();
    wrap_up();
  end
endmodule
bind rmp_top rmp_top_assertions i_rmp_top_assertions (.CORE_CLK(CORE_CLK), .RST(RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .READING_VALID(READING_VALID), .RESULT_VALID(RESULT_VALID), .RESULT(RESULT),
  .NEW_EXTREME(NEW_EXTREME), .LIMIT_BEEP(LIMIT_BEEP), .LIMIT_SRQ(LIMIT_SRQ),
  .SET_CONFLICT(SET_CONFLICT));
